// ==== rtl/ica_pkg.sv ====
// Package of the axis command acceptance block: map, codes, carriers.
// Assumes one 100 MHz core clock and a 32-bit AHB-Lite register bus.
package ica_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_REQ = 8'h04;
	localparam logic [7:0] OFS_PROG = 8'h08;
	localparam logic [7:0] OFS_OPND = 8'h0C;
	localparam logic [7:0] OFS_TGT_LO = 8'h10;
	localparam logic [7:0] OFS_TGT_HI = 8'h14;
	localparam logic [7:0] OFS_TGT_IMM = 8'h18;
	localparam logic [7:0] OFS_SPEED = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_ERRCODE = 8'h24;
	localparam logic [7:0] OFS_AXERR = 8'h28;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

	// Command bit positions in REQ and PROG
	localparam int CMD_N = 9;
	localparam int C_TGT = 0;
	localparam int C_HALT = 1;
	localparam int C_VEL = 2;
	localparam int C_TABLE = 3;
	localparam int C_DIRECT = 4;
	localparam int C_CONC = 5;
	localparam int C_ORIGIN = 6;
	localparam int C_INCH = 7;
	localparam int C_ABS = 8;
	// Commands that execute on a rising edge only
	localparam logic [8:0] PULSE_CMDS = 9'h17D;
	// Commands of the start family
	localparam logic [8:0] START_CMDS = 9'h1F8;
	// Commands that read an operand location
	localparam logic [8:0] OPND_CMDS = 9'h115;

	// CTRL fields
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_SUBCTX = 1;
	// STATUS fields
	localparam int ST_OPERR = 0;
	localparam int ST_STARTREQ = 1;
	localparam int ST_RUNSTART = 2;
	localparam int ST_DONE = 3;
	localparam int ST_HALT = 4;
	localparam int ST_STATE_LSB = 16;
	// Interrupt event bits
	localparam int EV_N = 4;
	localparam int EV_OPERR = 0;
	localparam int EV_AXERR = 1;
	localparam int EV_START = 2;
	localparam int EV_LOAD = 3;

	// Operand location code meaning an immediate constant
	localparam logic [7:0] LOC_IMM = 8'hFF;

	// Axis operation state codes (signed)
	localparam logic signed [15:0] AS_STANDBY = 16'sh0000;
	localparam logic signed [15:0] AS_STOPPED = 16'sh0001;
	localparam logic signed [15:0] AS_ERROR = -16'sh0001;
	localparam logic signed [15:0] AS_DEC_HALT = 16'sh0007;
	localparam logic signed [15:0] AS_DEC_INCH = 16'sh0008;
	localparam logic signed [15:0] AS_ANALYZE = 16'sh000B;

	// Error codes
	localparam logic [15:0] ERR_BAD_LOC = 16'd4101;
	localparam logic [15:0] ERR_NOT_USED = 16'd4116;
	localparam logic [15:0] AXERR_HALT_ON = 16'd1102;

	// Timing
	localparam int CLK_HZ = 100000000;
	localparam int SCAN_US = 10;
	localparam int SCAN_CYC = CLK_HZ / 1000000 * SCAN_US;
	localparam logic [31:0] SPEED_MAX = 32'd200000;

	// Request toward the motion profile generator
	typedef struct packed {
		logic start;
		logic [3:0] kind;
		logic target_load;
		logic [31:0] target;
		logic speed_load;
		logic [31:0] speed;
		logic halt;
		logic inch;
	} ica_motion_req_t;

	// Status from the motion profile generator
	typedef struct packed {
		logic signed [15:0] state;
		logic start_taken;
		logic run_start;
		logic finished;
		logic halt_finished;
	} ica_motion_stat_t;

endpackage

// ==== rtl/ica_scan_tick.sv ====
// Scan tick divider: one-cycle enable pulse every DIV core cycles.
// Assumes a single clock; the pulse paces all command evaluation.
`timescale 1ns/10ps
`default_nettype none
module ica_scan_tick #(
	parameter int DIV = 1000
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);
	logic [15:0] cnt_r;

	// Free running down counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 16'h0000;
		end else if (cnt_r == 16'h0000) begin
			cnt_r <= 16'(DIV - 1);
		end else begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end

	assign tick = (cnt_r == 16'h0000);
endmodule
`default_nettype wire

// ==== rtl/ica_edge_det.sv ====
// Per-command rising edge detector sampled at scan ticks.
// Assumes req is a same-clock level; sub marks interrupt/subroutine use.
`timescale 1ns/10ps
`default_nettype none
module ica_edge_det #(
	parameter int N = 9,
	parameter logic [N-1:0] PULSE = '1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic sub,
	input wire logic [N-1:0] req,
	output logic [N-1:0] rise
);
	logic [N-1:0] prev_r;
	logic [N-1:0] armed_r;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			logic edge_w;
			assign edge_w = tick & req[i] & ~prev_r[i];
			// Pulse commands in sub context skip their first edge
			assign rise[i] = edge_w & (~PULSE[i] | ~sub | armed_r[i]);
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					prev_r[i] <= 1'b0;
					armed_r[i] <= 1'b0;
				end else if (tick) begin
					prev_r[i] <= req[i];
					if (edge_w & sub) begin
						armed_r[i] <= 1'b1;
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ==== rtl/ica_top.sv ====
// Axis command acceptance: AHB-Lite registers, scan-paced command checks.
// Assumes a motion profile generator on the same clock drives MOTION_STAT.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Target change loads the new signed 32-bit pulse target.
// - Target comes as immediate word or low then high 16-bit words.
// - Stop, speed and target changes ignored in idle-type axis states.
// - Operation failures set the error flag and store the code.
// - Unusable operand location reports code 4101.
// - Axis not configured in use reports code 4116.
// - Start commands ignored while the start-request flag is set.
// - Start accepted after request flag clears, despite run-start flag.
// - Jog and stop evaluated every scan, raising errors even inactive.
// - Pulse commands execute only on a request rising edge.
// - In sub context pulse commands run from the second edge.
// - Start while stop active is refused with axis error 1102.
// - Stop-caused deceleration end leaves positioning-done cleared.
// - Out-of-range speed drives the axis at its speed limit.
module ica_top
	import ica_pkg::*;
#(
	parameter int SCAN_DIV = SCAN_CYC,
	parameter logic [7:0] LOC_COUNT = 8'h10,
	parameter logic [31:0] SPEED_LIMIT = SPEED_MAX
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire ica_pkg::ica_motion_stat_t MOTION_STAT,
	output ica_pkg::ica_motion_req_t MOTION_REQ,
	output logic IRQ
);
	import ica_pkg::*;

	// Bus phase registers
	logic wr_pend_r;
	logic rd_pend_r;
	logic [7:0] addr_r;
	// Software registers
	logic [1:0] ctrl_r;
	logic [8:0] req_r;
	logic [8:0] prog_r;
	logic [7:0] opnd_r;
	logic [15:0] tgt_lo_r;
	logic [15:0] tgt_hi_r;
	logic [31:0] tgt_imm_r;
	logic [31:0] speed_r;
	logic [3:0] irq_mask_r;
	// Block state
	logic op_err_r;
	logic [15:0] op_code_r;
	logic [15:0] ax_err_r;
	logic start_req_r;
	logic done_r;
	logic halt_act_r;
	logic halt_stop_r;
	logic [3:0] irq_stat_r;
	ica_motion_req_t mreq_r;

	// Address phase capture
	wire addr_ok = HSEL & HTRANS[1] & HREADY;
	wire [7:0] waddr = addr_r;

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
		end else begin
			wr_pend_r <= addr_ok & HWRITE;
			rd_pend_r <= addr_ok & ~HWRITE;
			if (addr_ok) begin
				addr_r <= HADDR[7:0];
			end
		end
	end

	// Write strobes per register
	wire we_ctrl = wr_pend_r & (waddr == OFS_CTRL);
	wire we_req = wr_pend_r & (waddr == OFS_REQ);
	wire we_prog = wr_pend_r & (waddr == OFS_PROG);
	wire we_opnd = wr_pend_r & (waddr == OFS_OPND);
	wire we_tlo = wr_pend_r & (waddr == OFS_TGT_LO);
	wire we_thi = wr_pend_r & (waddr == OFS_TGT_HI);
	wire we_timm = wr_pend_r & (waddr == OFS_TGT_IMM);
	wire we_speed = wr_pend_r & (waddr == OFS_SPEED);
	wire we_stat = wr_pend_r & (waddr == OFS_STATUS);
	wire we_istat = wr_pend_r & (waddr == OFS_IRQ_STAT);
	wire we_imask = wr_pend_r & (waddr == OFS_IRQ_MASK);

	// Plain software registers
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl_r <= 2'h0;
			req_r <= 9'h000;
			prog_r <= 9'h000;
			opnd_r <= LOC_IMM;
			tgt_lo_r <= 16'h0000;
			tgt_hi_r <= 16'h0000;
			tgt_imm_r <= 32'h0000_0000;
			speed_r <= 32'h0000_0000;
			irq_mask_r <= 4'h0;
		end else begin
			if (we_ctrl) ctrl_r <= HWDATA[1:0];
			if (we_req) req_r <= HWDATA[8:0];
			if (we_prog) prog_r <= HWDATA[8:0];
			if (we_opnd) opnd_r <= HWDATA[7:0];
			if (we_tlo) tgt_lo_r <= HWDATA[15:0];
			if (we_thi) tgt_hi_r <= HWDATA[15:0];
			if (we_timm) tgt_imm_r <= HWDATA;
			if (we_speed) speed_r <= HWDATA;
			if (we_imask) irq_mask_r <= HWDATA[3:0];
		end
	end

	// Scan pacing and edge detection
	logic tick;
	logic [8:0] rise;

	ica_scan_tick #(.DIV(SCAN_DIV)) u_tick (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.tick(tick)
	);

	ica_edge_det #(.N(CMD_N), .PULSE(PULSE_CMDS)) u_edge (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.tick(tick),
		.sub(ctrl_r[CTRL_SUBCTX]),
		.req(req_r),
		.rise(rise)
	);

	// Axis state decode, signed compare
	wire signed [15:0] ax_state = MOTION_STAT.state;
	wire idle_state = (ax_state == AS_STANDBY) | (ax_state == AS_STOPPED)
		| (ax_state == AS_ERROR) | (ax_state == AS_DEC_HALT)
		| (ax_state == AS_DEC_INCH) | (ax_state == AS_ANALYZE);

	// Jog and stop looked at every scan when present in the program
	wire lvl_eval = tick & (prog_r[C_HALT] | prog_r[C_INCH]);
	wire [8:0] fire = rise & ~(9'h1 << C_HALT);
	wire any_fire = |fire;
	wire enabled = ctrl_r[CTRL_ENABLE];

	// Lowest numbered firing command wins the scan
	logic [3:0] sel;
	always_comb begin
		sel = 4'h0;
		for (int k = CMD_N - 1; k >= 0; k--) begin
			if (fire[k]) sel = 4'(k);
		end
	end

	wire bad_loc = (opnd_r != LOC_IMM) & (opnd_r >= LOC_COUNT);
	wire is_start = START_CMDS[sel];
	wire not_used = ~enabled & (any_fire | lvl_eval);
	wire loc_err = enabled & any_fire & OPND_CMDS[sel] & bad_loc;
	wire op_fail = not_used | loc_err;
	wire cmd_ok = enabled & any_fire & ~loc_err;
	// Start family acceptance
	wire st_busy = cmd_ok & is_start & start_req_r;
	wire st_halt = cmd_ok & is_start & ~start_req_r & halt_act_r;
	wire st_go = cmd_ok & is_start & ~start_req_r & ~halt_act_r;
	// Changes honoured only in a moving state
	wire tgt_go = cmd_ok & (sel == 4'(C_TGT)) & ~idle_state;
	wire vel_go = cmd_ok & (sel == 4'(C_VEL)) & ~idle_state;
	// New target from immediate or word pair, low word first
	wire [31:0] new_tgt = (opnd_r == LOC_IMM) ? tgt_imm_r
		: {tgt_hi_r, tgt_lo_r};
	// Speed beyond range runs at the limit
	wire [31:0] new_spd = (speed_r > SPEED_MAX) ? SPEED_LIMIT
		: speed_r;

	// Operation error flag and code, set beats clear
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			op_err_r <= 1'b0;
			op_code_r <= 16'h0000;
		end else if (op_fail) begin
			op_err_r <= 1'b1;
			op_code_r <= not_used ? ERR_NOT_USED : ERR_BAD_LOC;
		end else if (we_stat & HWDATA[ST_OPERR]) begin
			op_err_r <= 1'b0;
		end
	end

	// Axis error code stays until a start is accepted
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ax_err_r <= 16'h0000;
		end else if (st_halt) begin
			ax_err_r <= AXERR_HALT_ON;
		end else if (st_go) begin
			ax_err_r <= 16'h0000;
		end
	end

	// Start request flag, stop level, completion flag
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			start_req_r <= 1'b0;
			halt_act_r <= 1'b0;
			halt_stop_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			if (st_go) begin
				start_req_r <= 1'b1;
			end else if (MOTION_STAT.start_taken) begin
				start_req_r <= 1'b0;
			end
			// Stop level sampled once per scan
			if (lvl_eval) begin
				halt_act_r <= enabled & prog_r[C_HALT] & req_r[C_HALT]
					& (~idle_state | halt_act_r);
			end
			if (halt_act_r & ~idle_state) begin
				halt_stop_r <= 1'b1;
			end else if (st_go) begin
				halt_stop_r <= 1'b0;
			end
			if (st_go) begin
				done_r <= 1'b0;
			end else if (MOTION_STAT.halt_finished) begin
				done_r <= 1'b0;
			end else if (MOTION_STAT.finished & ~halt_stop_r) begin
				done_r <= 1'b1;
			end
		end
	end

	// Requests toward the motion generator
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mreq_r <= '0;
		end else begin
			mreq_r.start <= st_go;
			mreq_r.target_load <= tgt_go;
			mreq_r.speed_load <= vel_go;
			if (st_go) mreq_r.kind <= sel;
			if (tgt_go) mreq_r.target <= new_tgt;
			if (vel_go | st_go) mreq_r.speed <= new_spd;
			mreq_r.halt <= halt_act_r;
			if (lvl_eval) begin
				mreq_r.inch <= enabled & prog_r[C_INCH] & req_r[C_INCH];
			end
		end
	end

	assign MOTION_REQ = mreq_r;

	// Interrupt events, write one to clear, set beats clear
	wire [3:0] ev;
	assign ev[EV_OPERR] = op_fail;
	assign ev[EV_AXERR] = st_halt;
	assign ev[EV_START] = st_go;
	assign ev[EV_LOAD] = tgt_go | vel_go;
	wire [3:0] clr = we_istat ? HWDATA[3:0] : 4'h0;

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_stat_r <= 4'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~clr) | ev;
		end
	end

	assign IRQ = |(irq_stat_r & irq_mask_r);

	// Status word
	wire [31:0] status_w = {ax_state, 11'h000, halt_act_r, done_r,
		MOTION_STAT.run_start, start_req_r, op_err_r};

	// Read data mux, zero for unmapped offsets and outside a read
	always_comb begin
		case (addr_r)
			OFS_CTRL: HRDATA = {30'h0, ctrl_r};
			OFS_REQ: HRDATA = {23'h0, req_r};
			OFS_PROG: HRDATA = {23'h0, prog_r};
			OFS_OPND: HRDATA = {24'h0, opnd_r};
			OFS_TGT_LO: HRDATA = {16'h0, tgt_lo_r};
			OFS_TGT_HI: HRDATA = {16'h0, tgt_hi_r};
			OFS_TGT_IMM: HRDATA = tgt_imm_r;
			OFS_SPEED: HRDATA = speed_r;
			OFS_STATUS: HRDATA = status_w;
			OFS_ERRCODE: HRDATA = {16'h0, op_code_r};
			OFS_AXERR: HRDATA = {16'h0, ax_err_r};
			OFS_IRQ_STAT: HRDATA = {28'h0, irq_stat_r};
			OFS_IRQ_MASK: HRDATA = {28'h0, irq_mask_r};
			default: HRDATA = 32'h0000_0000;
		endcase
		if (!rd_pend_r) begin
			HRDATA = 32'h0000_0000;
		end
	end

	// Zero wait state, always OKAY
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
endmodule
`default_nettype wire

// ==== tb/ica_checker.sv ====
// Checker of the axis command acceptance block, bound to its top.
// Assumes one clock; MOTION_STAT is driven on that clock.
`timescale 1ns/10ps
`default_nettype none
module ica_checker
	import ica_pkg::*;
#(
	parameter logic [31:0] SPEED_LIMIT = SPEED_MAX
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire ica_pkg::ica_motion_stat_t MOTION_STAT,
	input wire ica_pkg::ica_motion_req_t MOTION_REQ
);
	import ica_pkg::*;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	logic idle;
	logic pend_r;
	// States in which changes are ignored
	assign idle = MOTION_STAT.state inside {AS_STANDBY, AS_STOPPED,
		AS_ERROR, AS_DEC_HALT, AS_DEC_INCH, AS_ANALYZE};
	// Start issued, not yet taken
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST)
			pend_r <= 1'b0;
		else if (MOTION_STAT.start_taken)
			pend_r <= 1'b0;
		else if (MOTION_REQ.start)
			pend_r <= 1'b1;
	end
	// Command timing and interlocks
	property p_tgt_st; MOTION_REQ.target_load |-> !$past(idle); endproperty
	a_tgt_st: assert property (p_tgt_st) else $error("target in idle");
	property p_spd_st; MOTION_REQ.speed_load |-> !$past(idle); endproperty
	a_spd_st: assert property (p_spd_st) else $error("speed in idle");
	// Stop level is latched at a tick, then registered once more
	property p_halt_st; $rose(MOTION_REQ.halt) |-> !$past(idle, 2); endproperty
	a_halt_st: assert property (p_halt_st) else $error("halt in idle");
	property p_tgt_hold;
		$changed(MOTION_REQ.target) |-> MOTION_REQ.target_load;
	endproperty
	a_tgt_hold: assert property (p_tgt_hold) else $error("target moved");
	property p_spd_hold;
		$changed(MOTION_REQ.speed) |-> MOTION_REQ.speed_load
			|| MOTION_REQ.start;
	endproperty
	a_spd_hold: assert property (p_spd_hold) else $error("speed moved");
	property p_spd_lim;
		MOTION_REQ.speed_load |-> MOTION_REQ.speed <= SPEED_LIMIT;
	endproperty
	a_spd_lim: assert property (p_spd_lim) else $error("speed over");
	property p_gap; MOTION_REQ.start |=> !MOTION_REQ.start [*3]; endproperty
	a_gap: assert property (p_gap) else $error("start twice");
	property p_one;
		MOTION_REQ.start |-> !(MOTION_REQ.target_load || MOTION_REQ.speed_load);
	endproperty
	a_one: assert property (p_one) else $error("two commands");
	property p_kind; MOTION_REQ.start |-> MOTION_REQ.kind inside {[3:8]};
	endproperty
	a_kind: assert property (p_kind) else $error("bad start kind");
	property p_pend;
		MOTION_REQ.start |-> !$past(pend_r) || $past(MOTION_STAT.start_taken);
	endproperty
	a_pend: assert property (p_pend) else $error("start while pending");
	c_start: cover property (MOTION_REQ.start);
	c_tgt: cover property (MOTION_REQ.target_load);
	c_spd: cover property (MOTION_REQ.speed_load);
	c_halt: cover property ($rose(MOTION_REQ.halt));
endmodule
bind ica_top ica_checker #(.SPEED_LIMIT(SPEED_LIMIT)) i_chk (
	.CORE_CLK(CORE_CLK),
	.SYS_RST(SYS_RST),
	.MOTION_STAT(MOTION_STAT),
	.MOTION_REQ(MOTION_REQ)
);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench of the axis command acceptance block.
// Assumes ica_top with a 4-cycle scan and bus ready tied back.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ica_pkg::*;
	localparam int DIV = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hrdyo;
	logic hresp;
	logic irq;
	logic rph = 1'b0;
	ica_motion_stat_t ms = '0;
	ica_motion_req_t mr;
	logic [63:0] rq[$];
	logic [31:0] sq[$];
	logic [31:0] tq[$];
	logic [31:0] vq[$];
	logic [31:0] rnd;
	logic [31:0] e;
	logic [31:0] m;
	logic signed [15:0] ist[6] = '{AS_STANDBY, AS_STOPPED, AS_ERROR,
		AS_DEC_HALT, AS_DEC_INCH, AS_ANALYZE};
	int n_errors = 0;
	int n_checks = 0;
	int k;
	always #5 clk = ~clk;
	ica_top #(.SCAN_DIV(DIV)) i_dut (
		.CORE_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hrdyo), .HRDATA(hrdata), .HREADYOUT(hrdyo), .HRESP(hresp),
		.MOTION_STAT(ms), .MOTION_REQ(mr), .IRQ(irq)
	);
	task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] s);
		n_checks++;
		if (s !== x) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, x, s);
		end
	endtask
	task automatic summarize;
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Bounded wait for ready at a rising edge
	task automatic wrdy;
		int t;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (hrdyo !== 1'b1 && t < 20);
		if (t >= 20) begin
			n_errors++;
			summarize;
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		htrans <= 2'h2;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		wrdy;
		htrans <= 2'h0;
		hwdata <= d;
		wrdy;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k2);
		rq.push_back({x & k2, k2});
		xfer(a, 1'b0, 32'h0);
	endtask
	// Request bit low for two scans, then high for two scans
	task automatic cmd(input int b);
		wr(OFS_REQ, 32'h0);
		repeat (2 * DIV) @(posedge clk);
		wr(OFS_REQ, 32'h1 << b);
		repeat (2 * DIV) @(posedge clk);
	endtask
	// One-cycle generator status pulse; run_start keeps its value afterwards
	task automatic stp(input logic [3:0] p);
		ms[3:0] <= p;
		@(posedge clk);
		ms[3:0] <= {1'b0, p[2], 2'b00};
	endtask
	// Read data and motion pulses against the oldest notes
	always @(posedge clk) begin
		if (rph && rq.size() > 0) begin
			{e, m} = rq.pop_front();
			cmp("hrdata", e, hrdata & m);
			cmp("hresp", 32'h0, {31'h0, hresp});
		end
		if (hrdyo)
			rph <= hsel && htrans[1] && !hwrite;
		if (mr.start === 1'b1)
			cmp("kind", sq.size() ? sq.pop_front() : 32'hF, {28'h0, mr.kind});
		if (mr.target_load === 1'b1)
			cmp("target", tq.size() ? tq.pop_front() : ~mr.target, mr.target);
		if (mr.speed_load === 1'b1)
			cmp("speed", vq.size() ? vq.pop_front() : ~mr.speed, mr.speed);
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		summarize;
	end
	// Main sequence
	initial begin
		rnd = $urandom(32'hf9323ec0);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_CTRL, 32'h0, '1);
		rd(8'h40, 32'h0, '1);
		wr(OFS_IRQ_MASK, 32'h1);
		cmd(C_TABLE);
		rd(OFS_ERRCODE, ERR_NOT_USED, '1);
		rd(OFS_STATUS, 32'h1, 32'h1);
		cmp("irq", 32'h1, {31'h0, irq});
		wr(OFS_STATUS, 32'h1);
		wr(OFS_IRQ_STAT, 32'hF);
		rd(OFS_STATUS, 32'h0, 32'h1);
		cmp("irq", 32'h0, {31'h0, irq});
		wr(OFS_OPND, 32'h0);
		wr(OFS_CTRL, 32'h1);
		ms.state <= 16'sh0002;
		for (k = C_TABLE; k <= C_ABS; k++) begin
			sq.push_back(k);
			cmd(k);
			cmd(C_DIRECT);
			stp(4'hC);
		end
		wr(OFS_CTRL, 32'h3);
		cmd(C_TABLE);
		sq.push_back(C_TABLE);
		cmd(C_TABLE);
		stp(4'hC);
		wr(OFS_CTRL, 32'h1);
		stp(4'h6);
		rd(OFS_STATUS, 32'h8, 32'h8);
		rnd = $urandom;
		wr(OFS_TGT_LO, {~rnd[31:16], rnd[15:0]});
		wr(OFS_TGT_HI, {rnd[15:0], rnd[31:16]});
		tq.push_back(rnd);
		cmd(C_TGT);
		wr(OFS_SPEED, SPEED_MAX + 32'h1);
		vq.push_back(SPEED_MAX);
		cmd(C_VEL);
		rnd = $urandom;
		wr(OFS_OPND, 32'hFF);
		wr(OFS_TGT_IMM, rnd);
		tq.push_back(rnd);
		cmd(C_TGT);
		for (k = 0; k < 6; k++) begin
			ms.state <= ist[k];
			cmd(C_TGT);
			cmd(C_VEL);
		end
		ms.state <= 16'sh0002;
		wr(OFS_OPND, 32'h10);
		cmd(C_TGT);
		rd(OFS_ERRCODE, ERR_BAD_LOC, '1);
		rd(OFS_STATUS, 32'h1, 32'h1);
		cmp("irq", 32'h1, {31'h0, irq});
		wr(OFS_IRQ_MASK, 32'h0);
		@(posedge clk);
		cmp("irq", 32'h0, {31'h0, irq});
		wr(OFS_OPND, 32'h0);
		wr(OFS_PROG, 32'h2);
		wr(OFS_REQ, 32'h2);
		repeat (2 * DIV) @(posedge clk);
		cmp("halt", 32'h1, {31'h0, mr.halt});
		wr(OFS_REQ, 32'hA);
		repeat (2 * DIV) @(posedge clk);
		rd(OFS_AXERR, AXERR_HALT_ON, '1);
		stp(4'h5);
		stp(4'h6);
		rd(OFS_STATUS, 32'h0, 32'h8);
		wr(OFS_REQ, 32'h0);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_STATUS, 32'h1);
		repeat (2 * DIV) @(posedge clk);
		rd(OFS_ERRCODE, ERR_NOT_USED, '1);
		repeat (4) @(posedge clk);
		cmp("pending", 32'h0, rq.size() + sq.size() + tq.size() + vq.size());
		summarize;
	end
endmodule
`default_nettype wire
